// *** design/gro_pkg.sv ***
/*
  Shared constants and types of the gas reading output interface.
  Assumes a single 25 MHz clock; all long times are derived from it.
*/
// Contract
// R1: Auto zero pin low runs auto zero after 2 days, 5 more days, then weekly.
// R2: Manual zero pin low, auto pin high: manual zero after about 2 minutes.
// R3: Both pins high: normal operation with stored calibration.
// R4: Host never pulls both calibration pins low together.
// R5: Host ends manual zero between 2 and 4 minutes after start.
// R6: LEL frame: three spaces, tens, units, percent, space, L E L, CR LF.
// R7: Leading zero digits are sent as spaces.
// R8: Every frame ends with CR 0x0D then LF 0x0A.
// R9: Ppm frame: six blank-padded digits, space, p p m, CR LF.
// R10: Slave only at 7-bit address 0x31.
// R11: Address byte is 0x63 for read, 0x62 for write.
// R12: Master writes 'R' 0x52 to request a reading, then STOP.
// R13: Master reads 7 data bytes at 0x63, acknowledging each.
// R14: Master waits at least 1 ms between read bytes.
// R15: Alarm on above 25% LEL, off at or below 20% LEL.
// R16: Alarm thresholds are settable inputs.
// R17: PWM high time is 2 ms plus 1000 ms times reading over range.
// R18: UART 8N1 at 38400 default, 19200 or 9600 selectable.
// R19: PWM period is 2000 ms, low time is period minus high time.
package gro_pkg;
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned MS_CYCLES      = CLK_HZ / MS_PER_S;
  // ---------------------------------------------------------------
  // UART
  // ---------------------------------------------------------------
  localparam int unsigned BAUD_FAST      = 38_400;
  localparam int unsigned BAUD_MID       = 19_200;
  localparam int unsigned BAUD_SLOW      = 9_600;
  localparam logic [15:0] DIV_FAST       = 16'(CLK_HZ / BAUD_FAST);
  localparam logic [15:0] DIV_MID        = 16'(CLK_HZ / BAUD_MID);
  localparam logic [15:0] DIV_SLOW       = 16'(CLK_HZ / BAUD_SLOW);
  localparam logic [1:0]  BAUD_SEL_MID   = 2'h1;
  localparam logic [1:0]  BAUD_SEL_SLOW  = 2'h2;
  localparam logic [3:0]  UART_STOP_IDX  = 4'h9;
  localparam logic [3:0]  FRAME_LAST     = 4'hB;
  localparam logic [7:0]  CH_SP          = 8'h20;
  localparam logic [7:0]  CH_ZERO        = 8'h30;
  localparam logic [7:0]  CH_PCT         = 8'h25;
  localparam logic [7:0]  CH_L           = 8'h4C;
  localparam logic [7:0]  CH_E           = 8'h45;
  localparam logic [7:0]  CH_P           = 8'h70;
  localparam logic [7:0]  CH_M           = 8'h6D;
  localparam logic [7:0]  CH_CR          = 8'h0D;
  localparam logic [7:0]  CH_LF          = 8'h0A;
  localparam logic [6:0]  LEL_MAX_SHOWN  = 7'h63;
  // ---------------------------------------------------------------
  // I2C
  // ---------------------------------------------------------------
  localparam logic [6:0]  I2C_ADDR       = 7'h31;
  localparam logic [7:0]  I2C_REQ_CMD    = 8'h52;
  localparam logic [2:0]  I2C_RD_LAST    = 3'h6;
  localparam logic [3:0]  I2C_BITS       = 4'h8;
  typedef enum {I2C_IDLE, I2C_ADDR_RX, I2C_ACK, I2C_WR, I2C_RD, I2C_MACK} gro_i2c_state_t;
  // ---------------------------------------------------------------
  // Alarm, PWM, calibration
  // ---------------------------------------------------------------
  localparam logic [6:0]  ALARM_ON_LEL   = 7'h19;
  localparam logic [6:0]  ALARM_OFF_LEL  = 7'h14;
  localparam int unsigned PWM_BASE_MS    = 2;
  localparam int unsigned PWM_SPAN_MS    = 1000;
  localparam int unsigned PWM_PERIOD_MS  = 2000;
  localparam int unsigned RANGE_LEL      = 100;
  localparam int unsigned MANUAL_MIN     = 2;
  localparam int unsigned AUTO_FIRST_DAY = 2;
  localparam int unsigned AUTO_NEXT_DAY  = 5;
  localparam int unsigned AUTO_WEEK_DAY  = 7;
  localparam int unsigned S_PER_MIN      = 60;
  localparam int unsigned S_PER_DAY      = 86_400;
  localparam int unsigned MANUAL_S       = MANUAL_MIN * S_PER_MIN;
  localparam int unsigned AUTO_FIRST_S   = AUTO_FIRST_DAY * S_PER_DAY;
  localparam int unsigned AUTO_NEXT_S    = AUTO_NEXT_DAY * S_PER_DAY;
  localparam int unsigned AUTO_WEEK_S    = AUTO_WEEK_DAY * S_PER_DAY;
endpackage

// *** design/gro_top.sv ***
/*
  Gas reading outputs: UART frames, I2C slave, alarm, PWM, zero calibration.
  Assumes reading_valid pulses once per sample from the measurement core;
  pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module gro_top
  import gro_pkg::*;
#(
  parameter int unsigned MS_DIV      = MS_CYCLES,
  parameter int unsigned MAN_SECS    = MANUAL_S,
  parameter int unsigned AUTO1_SECS  = AUTO_FIRST_S,
  parameter int unsigned AUTO2_SECS  = AUTO_NEXT_S,
  parameter int unsigned AUTOW_SECS  = AUTO_WEEK_S
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [6:0]  reading_lel,
  input  wire logic [15:0] reading_ppm,
  input  wire logic        reading_valid,
  input  wire logic        ppm_mode,
  input  wire logic [1:0]  baud_sel,
  input  wire logic [6:0]  alarm_on_thr,
  input  wire logic [6:0]  alarm_off_thr,
  input  wire logic        pwm_enable,
  input  wire logic        manual_zero_pin_n,
  input  wire logic        auto_zero_pin_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             uart_txd,
  output logic             alarm_oe,
  output logic             pwm_out,
  output logic             manual_zero_cal_mode,
  output logic             auto_zero_cal_mode,
  output logic             cal_normal,
  output logic             manual_zero_calibration,
  output logic             periodic_auto_zero_calibration
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_raw, meta_q, sync_q;
  assign pin_raw = {sda_in, scl_in, auto_zero_pin_n, manual_zero_pin_n};
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge clk) begin
      if (reset) begin
        meta_q[g] <= 1'b1;
        sync_q[g] <= 1'b1;
      end else begin
        meta_q[g] <= pin_raw[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  logic [15:0] ms_cnt_q;
  logic [9:0]  s_cnt_q;
  logic        ms_tick, s_tick;
  assign ms_tick = (ms_cnt_q == 16'(MS_DIV - 1));
  assign s_tick  = ms_tick && (s_cnt_q == 10'(MS_PER_S - 1));
  always_ff @(posedge clk) begin
    if (reset || ms_tick) ms_cnt_q <= 16'h0;
    else                  ms_cnt_q <= ms_cnt_q + 16'h1;
  end
  always_ff @(posedge clk) begin
    if (reset || s_tick) s_cnt_q <= 10'h0;
    else if (ms_tick)    s_cnt_q <= s_cnt_q + 10'h1;
  end

  // ---------------------------------------------------------------
  // Calibration modes
  // ---------------------------------------------------------------
  logic [19:0] man_s_q, auto_s_q, auto_target;
  logic        man_done_q;
  logic [1:0]  stage_q;
  // Both pins low is illegal; fall back to normal rather than guess
  assign manual_zero_cal_mode = !sync_q[0] && sync_q[1]; // R2 R4
  assign auto_zero_cal_mode   = sync_q[0] && !sync_q[1]; // R1 R4
  assign cal_normal = !manual_zero_cal_mode && !auto_zero_cal_mode; // R3
  assign auto_target = (stage_q == 2'h0) ? 20'(AUTO1_SECS) :
                       (stage_q == 2'h1) ? 20'(AUTO2_SECS) : 20'(AUTOW_SECS); // R1

  always_ff @(posedge clk) begin
    manual_zero_calibration <= 1'b0;
    if (reset || !manual_zero_cal_mode) begin
      man_s_q    <= 20'h0;
      man_done_q <= 1'b0;
    end else if (s_tick && !man_done_q) begin
      if (man_s_q == 20'(MAN_SECS - 1)) begin
        manual_zero_calibration <= 1'b1; // R2
        man_done_q              <= 1'b1;
      end
      man_s_q <= man_s_q + 20'h1;
    end
  end

  always_ff @(posedge clk) begin
    periodic_auto_zero_calibration <= 1'b0;
    if (reset || !auto_zero_cal_mode) begin
      auto_s_q <= 20'h0;
      stage_q  <= 2'h0;
    end else if (s_tick) begin
      if (auto_s_q == auto_target - 20'h1) begin
        periodic_auto_zero_calibration <= 1'b1; // R1
        auto_s_q <= 20'h0;
        if (stage_q != 2'h2) stage_q <= stage_q + 2'h1;
      end else begin
        auto_s_q <= auto_s_q + 20'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reading hold and alarm
  // ---------------------------------------------------------------
  logic [6:0]  lel_q;
  logic [15:0] ppm_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      lel_q    <= 7'h0;
      ppm_q    <= 16'h0;
      alarm_oe <= 1'b0;
    end else if (reading_valid) begin
      lel_q <= reading_lel;
      ppm_q <= reading_ppm;
      if (reading_lel > alarm_on_thr)        alarm_oe <= 1'b1; // R15 R16
      else if (reading_lel <= alarm_off_thr) alarm_oe <= 1'b0; // R15 R16
    end
  end

  // ---------------------------------------------------------------
  // UART frame builder
  // ---------------------------------------------------------------
  function automatic logic [7:0] dec_char(input logic [16:0] v, input logic [2:0] k);
    logic [16:0] p;
    logic [16:0] d;
    case (k)
      3'h0:    p = 17'h1;
      3'h1:    p = 17'hA;
      3'h2:    p = 17'h64;
      3'h3:    p = 17'h3E8;
      3'h4:    p = 17'h2710;
      default: p = 17'h186A0;
    endcase
    d = (v / p) % 17'hA;
    if (k != 3'h0 && v < p) return CH_SP; // R7
    return CH_ZERO + d[7:0];
  endfunction

  function automatic logic [7:0] frame_char(input logic [3:0] i, input logic ppm,
                                            input logic [16:0] v);
    if (i == 4'hA) return CH_CR; // R8
    if (i == 4'hB) return CH_LF; // R8
    if (ppm) begin
      if (i < 4'h6) return dec_char(v, 3'(4'h5 - i)); // R9
      case (i)
        4'h6:    return CH_SP;
        4'h9:    return CH_M;
        default: return CH_P; // R9
      endcase
    end
    case (i)
      4'h3:    return dec_char(v, 3'h1); // R6
      4'h4:    return dec_char(v, 3'h0); // R6
      4'h5:    return CH_PCT;
      4'h7:    return CH_L;
      4'h8:    return CH_E;
      4'h9:    return CH_L; // R6
      default: return CH_SP;
    endcase
  endfunction

  gro_uart_if  tx_if ();
  logic        fr_busy_q, fr_ppm_q;
  logic [3:0]  fr_idx_q;
  logic [16:0] fr_val_q;
  assign tx_if.valid    = fr_busy_q;
  assign tx_if.data     = frame_char(fr_idx_q, fr_ppm_q, fr_val_q);
  assign tx_if.baud_div = (baud_sel == BAUD_SEL_MID)  ? DIV_MID :
                          (baud_sel == BAUD_SEL_SLOW) ? DIV_SLOW : DIV_FAST; // R18

  // A reading that arrives mid-frame is skipped; the next sample follows soon
  always_ff @(posedge clk) begin
    if (reset) begin
      fr_busy_q <= 1'b0;
      fr_ppm_q  <= 1'b0;
      fr_idx_q  <= 4'h0;
      fr_val_q  <= 17'h0;
    end else if (!fr_busy_q) begin
      if (reading_valid) begin
        fr_busy_q <= 1'b1;
        fr_idx_q  <= 4'h0;
        fr_ppm_q  <= ppm_mode;
        fr_val_q  <= ppm_mode ? {1'b0, reading_ppm} :
                     {10'h0, (reading_lel > LEL_MAX_SHOWN) ? LEL_MAX_SHOWN : reading_lel};
      end
    end else if (tx_if.ready) begin
      fr_idx_q <= fr_idx_q + 4'h1;
      if (fr_idx_q == FRAME_LAST) fr_busy_q <= 1'b0;
    end
  end

  gro_uart_tx u_tx (.clk(clk), .reset(reset), .up(tx_if.snk), .txd(uart_txd));

  // ---------------------------------------------------------------
  // I2C slave
  // ---------------------------------------------------------------
  gro_i2c_state_t st_q;
  logic       scl_p_q, sda_p_q, rw_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [2:0] rd_idx_q;
  logic [7:0] snap_q [0:6];
  logic       scl_rise, scl_fall, i2c_start, i2c_stop;
  assign scl_rise  = sync_q[2] && !scl_p_q;
  assign scl_fall  = !sync_q[2] && scl_p_q;
  assign i2c_start = sync_q[2] && scl_p_q && sda_p_q && !sync_q[3];
  assign i2c_stop  = sync_q[2] && scl_p_q && !sda_p_q && sync_q[3];
  assign sda_out   = 1'b0;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= sync_q[2];
      sda_p_q <= sync_q[3];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= I2C_IDLE;
      sda_oe <= 1'b0;
      rw_q <= 1'b0;
      sh_q <= 8'h0;
      bit_q <= 4'h0;
      rd_idx_q <= 3'h0;
      for (int i = 0; i < 7; i++) snap_q[i] <= 8'h0;
    end else if (i2c_start) begin
      st_q   <= I2C_ADDR_RX;
      bit_q  <= 4'h0;
      sda_oe <= 1'b0;
    end else if (i2c_stop) begin
      st_q   <= I2C_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == I2C_ADDR_RX || st_q == I2C_WR) begin
        sh_q  <= {sh_q[6:0], sync_q[3]};
        bit_q <= bit_q + 4'h1;
      end else if (st_q == I2C_RD) begin
        bit_q <= bit_q + 4'h1;
      end else if (st_q == I2C_MACK && sync_q[3]) begin
        st_q <= I2C_IDLE; // R13
      end
    end else if (scl_fall) begin
      case (st_q)
        I2C_ADDR_RX: if (bit_q == I2C_BITS) begin
          if (sh_q[7:1] == I2C_ADDR) begin // R10
            st_q     <= I2C_ACK;
            sda_oe   <= 1'b1;
            rw_q     <= sh_q[0]; // R11
            rd_idx_q <= 3'h0;
          end else begin
            st_q <= I2C_IDLE;
          end
        end
        I2C_WR: if (bit_q == I2C_BITS) begin
          st_q   <= I2C_ACK;
          sda_oe <= 1'b1;
          if (sh_q == I2C_REQ_CMD) begin // R12
            snap_q[0] <= {1'b0, lel_q};
            snap_q[1] <= ppm_q[15:8];
            snap_q[2] <= ppm_q[7:0];
            snap_q[3] <= {alarm_oe, manual_zero_cal_mode, auto_zero_cal_mode, 5'h00};
            snap_q[4] <= 8'h00;
            snap_q[5] <= 8'h00;
            snap_q[6] <= 8'h00;
          end
        end
        I2C_ACK: begin
          bit_q <= 4'h0;
          if (rw_q) begin
            st_q   <= I2C_RD;
            sh_q   <= snap_q[rd_idx_q];
            sda_oe <= !snap_q[rd_idx_q][7]; // R13
          end else begin
            st_q   <= I2C_WR;
            sda_oe <= 1'b0;
          end
        end
        I2C_RD: if (bit_q == I2C_BITS) begin
          st_q   <= I2C_MACK;
          sda_oe <= 1'b0;
        end else begin
          sh_q   <= {sh_q[6:0], 1'b0};
          sda_oe <= !sh_q[6];
        end
        I2C_MACK: begin
          // Reads past the seventh byte repeat the last one
          if (rd_idx_q != I2C_RD_LAST) rd_idx_q <= rd_idx_q + 3'h1;
          st_q   <= I2C_ACK;
          sda_oe <= 1'b0;
          rw_q   <= 1'b1;
        end
        default: st_q <= I2C_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // PWM output
  // ---------------------------------------------------------------
  logic [10:0] pwm_ms_q, high_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_ms_q <= 11'h0;
      high_q   <= 11'(PWM_BASE_MS);
      pwm_out  <= 1'b0;
    end else begin
      pwm_out <= pwm_enable && (pwm_ms_q < high_q); // R17 R19
      if (ms_tick) begin
        if (pwm_ms_q == 11'(PWM_PERIOD_MS - 1)) begin // R19
          pwm_ms_q <= 11'h0;
          high_q   <= 11'(PWM_BASE_MS + (32'(lel_q) * PWM_SPAN_MS) / RANGE_LEL); // R17
        end else begin
          pwm_ms_q <= pwm_ms_q + 11'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_alarm_on;
    reading_valid && reading_lel > alarm_on_thr |=> alarm_oe;
  endproperty
  a_alarm_on: assert property (p_alarm_on) else $error("alarm not raised"); // R15
  property p_alarm_off;
    reading_valid && reading_lel <= alarm_off_thr && reading_lel <= alarm_on_thr |=> !alarm_oe;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm not cleared"); // R16
  property p_mode_excl;
    !(manual_zero_cal_mode && auto_zero_cal_mode);
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("two cal modes"); // R4
  property p_man_pulse;
    manual_zero_calibration |-> manual_zero_cal_mode && $past(s_tick);
  endproperty
  a_man_pulse: assert property (p_man_pulse) else $error("stray manual cal"); // R2
  property p_auto_pulse;
    periodic_auto_zero_calibration |-> auto_zero_cal_mode && auto_s_q == 20'h0;
  endproperty
  a_auto_pulse: assert property (p_auto_pulse) else $error("stray auto cal"); // R1
  property p_normal;
    cal_normal |-> !manual_zero_calibration && !periodic_auto_zero_calibration;
  endproperty
  a_normal: assert property (p_normal) else $error("cal in normal mode"); // R3
  property p_crlf;
    fr_busy_q && fr_idx_q == 4'hA && tx_if.ready |=> tx_if.data == CH_LF;
  endproperty
  a_crlf: assert property (p_crlf) else $error("CR not followed by LF"); // R8
  property p_pct;
    fr_busy_q && !fr_ppm_q && fr_idx_q == 4'h5 |-> tx_if.data == CH_PCT;
  endproperty
  a_pct: assert property (p_pct) else $error("percent sign missing"); // R6
  property p_blank;
    fr_busy_q && fr_idx_q == 4'h3 && !fr_ppm_q |-> tx_if.data != CH_ZERO;
  endproperty
  a_blank: assert property (p_blank) else $error("leading zero sent"); // R7
  property p_addr_ack;
    st_q == I2C_ADDR_RX && scl_fall && bit_q == I2C_BITS && !i2c_start && !i2c_stop
      && sh_q[7:1] != I2C_ADDR |=> !sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("acked foreign address"); // R10
  property p_pwm_period;
    pwm_ms_q < 11'(PWM_PERIOD_MS);
  endproperty
  a_pwm_period: assert property (p_pwm_period) else $error("pwm period overrun"); // R19

  c_frame: cover property (fr_busy_q && fr_idx_q == FRAME_LAST && tx_if.ready);
  c_req:   cover property (st_q == I2C_WR && scl_fall && sh_q == I2C_REQ_CMD);
  c_read:  cover property (st_q == I2C_MACK && rd_idx_q == I2C_RD_LAST);
  c_alarm: cover property ($rose(alarm_oe));
endmodule // gro_top

// *** design/gro_uart_if.sv ***
/*
  Byte stream from the frame builder to the UART transmitter.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface gro_uart_if;
  logic [7:0]  data;
  logic        valid;
  logic        ready;
  logic [15:0] baud_div;
  modport src (output data, output valid, output baud_div, input ready);
  modport snk (input data, input valid, input baud_div, output ready);
endinterface

// *** design/gro_uart_tx.sv ***
/*
  8N1 UART transmitter with its own baud enable divider.
  Assumes baud_div is at least 2 and stable while valid is high.
*/
`timescale 1ns/1ps
module gro_uart_tx
  import gro_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  gro_uart_if.snk     up,
  output logic        txd
);
  logic        busy_q;
  logic [8:0]  sh_q;
  logic [3:0]  nbit_q;
  logic [15:0] cnt_q;
  logic [15:0] div_q;
  logic        tick;

  assign up.ready = !busy_q;
  assign tick     = (cnt_q == div_q - 16'h1);

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      txd    <= 1'b1;
      sh_q   <= 9'h1FF;
      nbit_q <= 4'h0;
      cnt_q  <= 16'h0;
      div_q  <= DIV_FAST;
    end else if (!busy_q) begin
      if (up.valid) begin
        busy_q <= 1'b1;
        txd    <= 1'b0;
        sh_q   <= {1'b1, up.data};
        nbit_q <= 4'h0;
        cnt_q  <= 16'h0;
        div_q  <= up.baud_div; // R18
      end
    end else if (tick) begin
      cnt_q <= 16'h0;
      if (nbit_q == UART_STOP_IDX) begin
        busy_q <= 1'b0;
      end else begin
        txd    <= sh_q[0];
        sh_q   <= {1'b1, sh_q[8:1]};
        nbit_q <= nbit_q + 4'h1;
      end
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end

  // Line stays high whenever the transmitter is idle
  property p_idle_high;
    @(posedge clk) disable iff (reset) !busy_q && !up.valid |=> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("txd low while idle"); // R18
endmodule // gro_uart_tx

// *** tb/gro_host_model.sv ***
/*
  Host side model: 8N1 UART receiver and the I2C wiring with pull-up.
  Assumes one shared clock and the divider given as DIV.
*/
`timescale 1ns/1ps
module gro_host_model
  import gro_pkg::*;
#(
  parameter int unsigned DIV = DIV_FAST
)(
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic scl_m,
  input  wire logic sda_m,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic [7:0] rx_q [$];
  logic [7:0] b;
  // ------
  // Bus wiring
  // ------
  assign scl = scl_m;
  // Pull-up: the line is low whenever either party pulls it
  assign sda = sda_m & ~sda_oe;
  // ------
  // Receiver
  // ------
  // Sampling mid-bit tolerates the one-cycle gap between bytes
  initial begin
    forever begin
      @(posedge clk);
      if (txd === 1'b0) begin
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (DIV) @(posedge clk);
          b[i] = txd;
        end
        repeat (DIV) @(posedge clk);
        rx_q.push_back((txd === 1'b1) ? b : 8'hEE);
      end
    end
  end
endmodule // gro_host_model

// *** tb/testbench.sv ***
/*
  Self-checking bench of gro_top: LEL frame, I2C acknowledge, zero
  calibration, PWM timing, alarm hysteresis.
  Assumes short millisecond and calibration parameters for a brief run.
*/
`timescale 1ns/1ps
module testbench;
  import gro_pkg::*;
  localparam int unsigned MSD = 4;
  localparam int unsigned SEC = MSD * MS_PER_S;
  localparam int unsigned P   = 100;
  logic       clk = 1'b0, reset = 1'b1, rv = 1'b0, man_n = 1'b1, auto_n = 1'b1;
  logic       scl_m = 1'b1, sda_m = 1'b1, scl, sda, sda_oe, txd, alarm_oe, pwm_out;
  logic       man_mode, auto_mode, cal_norm, man_p, auto_p;
  logic       ppm_md = 1'b0, pwm_en = 1'b1;
  logic [1:0] bsel = 2'h0;
  logic [15:0] ppm = 16'h0DAC;
  logic [6:0] lel = 7'h00, on_thr = ALARM_ON_LEL, off_thr = ALARM_OFF_LEL;
  int         n_fail = 0, num_checks = 0, cyc_cnt = 0;
  initial forever #20 clk = ~clk;
  gro_top #(.MS_DIV(MSD), .MAN_SECS(3), .AUTO1_SECS(2), .AUTO2_SECS(3), .AUTOW_SECS(4))
  u_gro_top (.clk(clk), .reset(reset), .reading_lel(lel), .reading_ppm(ppm),
    .reading_valid(rv), .ppm_mode(ppm_md), .baud_sel(bsel), .alarm_on_thr(on_thr),
    .alarm_off_thr(off_thr), .pwm_enable(pwm_en), .manual_zero_pin_n(man_n),
    .auto_zero_pin_n(auto_n), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .uart_txd(txd), .alarm_oe(alarm_oe), .pwm_out(pwm_out), .manual_zero_cal_mode(man_mode),
    .auto_zero_cal_mode(auto_mode), .cal_normal(cal_norm), .manual_zero_calibration(man_p),
    .periodic_auto_zero_calibration(auto_p));
  gro_host_model #(.DIV(DIV_FAST)) u_gro_host_model (.clk(clk), .txd(txd), .scl_m(scl_m),
    .sda_m(sda_m), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic send(input logic [6:0] v);
    @(posedge clk);
    lel <= v;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic i2c_bit(input logic b, output logic ack);
    @(posedge clk) sda_m <= b;
    repeat (P) @(posedge clk);
    scl_m <= 1'b1;
    repeat (P) @(posedge clk);
    ack = sda_oe;
    scl_m <= 1'b0;
  endtask
  task automatic i2c_addr(input logic [7:0] a, input logic e);
    logic k;
    @(posedge clk) sda_m <= 1'b0;
    repeat (P) @(posedge clk);
    scl_m <= 1'b0;
    for (int i = 7; i >= 0; i--) i2c_bit(a[i], k);
    i2c_bit(1'b1, k);
    chk("i2c ack", e, k);
    @(posedge clk) sda_m <= 1'b0;
    repeat (P) @(posedge clk);
    scl_m <= 1'b1;
    repeat (P) @(posedge clk);
    sda_m <= 1'b1;
    repeat (P) @(posedge clk);
  endtask
  task automatic wait_cal(input bit au, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (((au ? auto_p : man_p) !== 1'b1) && c < 6 * SEC);
  endtask
  // ------
  // Timeout
  // ------
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 100000) begin
      n_fail++;
      finish_test();
    end
  end
  // ------
  // Sequence
  // ------
  initial begin
    logic [6:0] av [6] = '{7'h19, 7'h1A, 7'h15, 7'h14, 7'h0B, 7'h05};
    logic       ae [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk("cal levels", 3'b001, {man_mode, auto_mode, cal_norm});
    send(7'h07);
    fork
      begin : uart
        logic [7:0] ex [12] = '{CH_SP, CH_SP, CH_SP, CH_SP, CH_ZERO + 8'h07, CH_PCT,
                                CH_SP, CH_L, CH_E, CH_L, CH_CR, CH_LF};
        int w;
        for (w = 0; u_gro_host_model.rx_q.size() < 12 && w < 90000; w++) @(posedge clk);
        for (int i = 0; i < 12; i++) chk("uart byte", ex[i], u_gro_host_model.rx_q[i]);
      end
      begin : cal
        int n;
        @(posedge clk) man_n <= 1'b0;
        wait_cal(0, n);
        chk("manual time", 1, n >= 2 * SEC && n <= 3 * SEC + 8);
        chk("manual levels", 3'b100, {man_mode, auto_mode, cal_norm});
        @(posedge clk) man_n <= 1'b1;
        // Pins are never low together, the host keeps that
        repeat (4) @(posedge clk);
        auto_n <= 1'b0;
        wait_cal(1, n);
        chk("auto first", 1, n >= SEC && n <= 2 * SEC + 8);
        wait_cal(1, n);
        chk("auto second", 3 * SEC, n);
        wait_cal(1, n);
        chk("auto weekly", 4 * SEC, n);
        chk("auto levels", 3'b010, {man_mode, auto_mode, cal_norm});
        @(posedge clk) auto_n <= 1'b1;
      end
      begin : pwm
        int h, l;
        @(posedge pwm_out);
        @(posedge pwm_out);
        for (h = 0; pwm_out === 1'b1 && h < 9000; h++) begin @(posedge clk); #1; end
        for (l = 0; pwm_out !== 1'b1 && l < 9000; l++) begin @(posedge clk); #1; end
        chk("pwm high", (PWM_BASE_MS + 7 * PWM_SPAN_MS / RANGE_LEL) * MSD, h);
        chk("pwm low", PWM_PERIOD_MS * MSD - h, l);
      end
      begin : i2c
        i2c_addr(8'h64, 1'b0);
        i2c_addr(8'h62, 1'b1);
        i2c_addr(8'h63, 1'b1);
      end
    join
    for (int i = 0; i < 6; i++) begin
      if (i == 4) begin
        @(posedge clk);
        on_thr <= 7'h0A;
        off_thr <= 7'h05;
      end
      send(av[i]);
      chk("alarm", ae[i], alarm_oe);
    end
    @(posedge clk) pwm_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("pwm disabled", 1'b0, pwm_out);
    finish_test();
  end
endmodule // testbench
